// *** dv/remote_uart.sv ***
// Remote serial transceiver: drives the receive line and decodes transmitted frames
`timescale 1ns/1ps
module remote_uart (
   input logic aclk,
   input logic txd,
   input logic rxd_o,
   input logic rxd_oe,
   output logic rxd_i
);
   int bit_cyc = 16;
   int nbits = 10;
   int got_q[$];
   longint t_q[$];
   bit shift_mode = 1'h0;
   bit sh_feed = 1'h0;
   logic [7:0] sh_got = 8'h00;
   logic [7:0] sh_out = 8'h00;

   // Shift mode: device data taken on the rising shift clock
   always @(posedge txd) begin
      if (shift_mode && rxd_oe) begin
         sh_got = {rxd_o, sh_got[7:1]};
         t_q.push_back($time);
      end
   end

   // Shift mode: next bit for the device on the falling shift clock
   always @(negedge txd) begin
      if (shift_mode && sh_feed) begin
         rxd_i <= sh_out[0];
         sh_out = {1'h1, sh_out[7:1]};
      end
   end

   // Line idles high between frames
   initial rxd_i = 1'h1;

   // Samples mid-bit: data LSB first, then ninth bit when nbits is 10, then stop bit
   initial begin : mon
      int v;
      longint t0;
      forever begin
         @(negedge txd);
         t0 = $time;
         repeat (bit_cyc / 2) @(posedge aclk);
         if (txd === 1'h0 && !shift_mode) begin
            v = 0;
            for (int i = 0; i < nbits; i++) begin
               repeat (bit_cyc) @(posedge aclk);
               v[i] = txd;
            end
            got_q.push_back(v);
            t_q.push_back(t0);
         end
      end
   end

   // Start bit low, then n bits LSB first, each bit_cyc clocks
   task automatic send(input int v, input int n);
      @(posedge aclk);
      rxd_i <= 1'h0;
      repeat (bit_cyc) @(posedge aclk);
      for (int i = 0; i < n; i++) begin
         rxd_i <= v[i];
         repeat (bit_cyc) @(posedge aclk);
      end
      rxd_i <= 1'h1;
   endtask
endmodule

// *** dv/test_enhanced_uart.sv ***
// Self-checking bench for the enhanced UART
`timescale 1ns/1ps
module test_enhanced_uart;
   import uart_pkg::*;
   logic aclk = 1'h0, aresetn = 1'h0, por_n = 1'h0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic t1_overflow = 1'h0, t1_en = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, rxd_o, rxd_oe, txd, break_reset;
   logic rem_rxd, rxd_line;
   logic [1:0] bresp, rresp, bresp_got, rresp_got;
   logic [31:0] rdata;
   logic [31:0] lfsr_st = 32'hE24AB3C5;
   int error_cnt = 0, n_checks = 0, brk_cnt = 0;
   int exp_q[$];
   // mode, doubling select, rate source, clocks per bit
   int cfg [5][4] = '{'{2, 1, 0, 16}, '{2, 0, 0, 32}, '{1, 1, 1, 32}, '{3, 1, 0, 32},
                      '{3, 0, 0, 64}};

   always #20 aclk = ~aclk;
   assign rxd_line = rxd_oe ? rxd_o : rem_rxd;

   enhanced_uart uut (.aclk(aclk), .aresetn(aresetn), .por_n(por_n), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .t1_overflow(t1_overflow), .rxd_i(rxd_line), .rxd_o(rxd_o),
      .rxd_oe(rxd_oe), .txd(txd), .break_reset(break_reset));

   remote_uart rem (.aclk(aclk), .txd(txd), .rxd_o(rxd_o), .rxd_oe(rxd_oe), .rxd_i(rem_rxd));

   // Timer 1 overflow every second clock
   always @(posedge aclk) begin
      t1_overflow <= t1_en & ~t1_overflow;
      if (break_reset === 1'h1) brk_cnt++;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task end_sim;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic aw_ok, w_ok;
      aw_ok = 1'h0;
      w_ok = 1'h0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (!aw_ok && awready === 1'h1) begin
            aw_ok = 1'h1;
            awvalid <= 1'h0;
         end
         if (!w_ok && wready === 1'h1) begin
            w_ok = 1'h1;
            wvalid <= 1'h0;
         end
      end
      while (bvalid !== 1'h1) @(posedge aclk);
      bresp_got = bresp;
      bready <= 1'h0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do @(posedge aclk); while (arready !== 1'h1);
      arvalid <= 1'h0;
      do @(posedge aclk); while (rvalid !== 1'h1);
      d = rdata;
      rresp_got = rresp;
      rready <= 1'h0;
   endtask

   task automatic wait_tx(input int n);
      for (int i = 0; i < 3000 && rem.got_q.size() < n; i++) @(posedge aclk);
   endtask

   task automatic wait_rx;
      logic [31:0] c;
      c = 32'h0;
      for (int i = 0; i < 50 && c[CTL_RI] !== 1'h1; i++) rd(A_CTL, c);
   endtask

   initial begin : watchdog
      repeat (60000) @(posedge aclk);
      error_cnt++;
      $display("watchdog expired");
      end_sim;
   end

   initial begin : main
      logic [31:0] r;
      logic [7:0] d;
      logic b9;
      int m, nb, v;
      longint dt;
      repeat (20) @(posedge aclk);
      aresetn <= 1'h1;
      por_n <= 1'h1;
      rd(A_CTL, r);
      chk(r, {24'h0, CTL_RST});
      rd(8'h40, r);
      chk(r, 32'h0);
      chk(rresp_got, RESP_SLVERR);
      wr(8'h44, 8'hFF);
      chk(bresp_got, RESP_SLVERR);
      $display("test registers done");
      // Divisor 1: one tick every two clocks
      wr(A_DIVL, 8'h01);
      wr(A_DIVH, 8'h00);
      t1_en <= 1'h1;
      for (int k = 0; k < 5; k++) begin
         m = cfg[k][0];
         nb = (m == 1) ? 9 : 10;
         rem.bit_cyc = cfg[k][3];
         rem.nbits = nb;
         wr(A_PWR, {cfg[k][1][0], 7'h00});
         wr(A_SRC, {7'h00, cfg[k][2][0]});
         lfsr_st = lfsr(lfsr_st);
         d = lfsr_st[7:0];
         b9 = lfsr_st[8];
         wr(A_CTL, {m[1:0], 2'h1, b9, 3'h0});
         wr(A_BUF, d);
         exp_q.push_back(int'({b9, d}) | (1 << (nb - 1)));
         wait_tx(1);
         chk(rem.got_q.pop_front(), exp_q.pop_front());
         v = int'({lfsr_st[9], lfsr_st[31:24]}) | (1 << (nb - 1));
         rem.send(v, nb);
         wait_rx();
         rd(A_BUF, r);
         chk(r, {24'h0, lfsr_st[31:24]});
         rd(A_CTL, r);
         chk(r, {24'h0, m[1:0], 2'h1, b9, (m == 1) ? 1'h1 : lfsr_st[9], 2'h3});
         $display("test rate %0d done", k);
      end
      wr(A_PWR, 8'h80);
      wr(A_CTL, 8'h90);
      rem.bit_cyc = 16;
      rem.nbits = 10;
      rem.send(32'h0AA, 10);
      wait_rx();
      rd(A_STAT, r);
      chk(r[STAT_FE], 1'h1);
      wr(A_PWR, 8'hC0);
      rd(A_CTL, r);
      chk(r[CTL_SM0], 1'h1);
      wr(A_CTL, 8'h10);
      wr(A_PWR, 8'h80);
      rd(A_CTL, r);
      chk(r[7:6], 2'h2);
      rd(A_STAT, r);
      chk(r[STAT_FE], 1'h0);
      $display("test framing done");
      wr(A_RST, 8'h02);
      brk_cnt = 0;
      rem.send(0, 11);
      repeat (4) @(posedge aclk);
      rd(A_STAT, r);
      chk(r[STAT_BRK], 1'h1);
      rd(A_RST, r);
      chk(r[1:0], 2'h3);
      chk(brk_cnt, 1);
      $display("test break done");
      rem.t_q.delete();
      rem.got_q.delete();
      wr(A_STAT, 8'h80);
      wr(A_CTL, 8'h98);
      wr(A_BUF, 8'h3C);
      rd(A_CTL, r);
      chk(r[CTL_TI], 1'h1);
      wr(A_CTL, 8'h90);
      wr(A_BUF, 8'hC3);
      wait_tx(2);
      chk(rem.got_q.pop_front(), 32'h33C);
      chk(rem.got_q.pop_front(), 32'h2C3);
      dt = (rem.t_q[1] - rem.t_q[0]) / 40;
      chk(dt >= 176 && dt <= 178, 1'h1);
      $display("test double buffer done");
      // Address recognition: only a matching address frame is kept
      wr(A_ADDR, 8'h5A);
      wr(A_CTL, 8'hB0);
      rem.send(32'h3A5, 10);
      rd(A_CTL, r);
      chk(r[CTL_RI], 1'h0);
      rem.send(32'h35A, 10);
      wait_rx();
      rd(A_BUF, r);
      chk(r, 32'h5A);
      $display("test address done");
      // Shift mode: byte out on rxd with clock on txd, then byte in
      wr(A_STAT, 8'h00);
      rem.t_q.delete();
      rem.shift_mode = 1'h1;
      lfsr_st = lfsr(lfsr_st);
      wr(A_CTL, 8'h00);
      wr(A_BUF, lfsr_st[7:0]);
      repeat (150) @(posedge aclk);
      chk(rem.sh_got, lfsr_st[7:0]);
      dt = (rem.t_q[7] - rem.t_q[0]) / 40;
      chk(dt, 32'h70);
      rem.sh_out = lfsr_st[15:8];
      rem.sh_feed = 1'h1;
      wr(A_CTL, 8'h10);
      wait_rx();
      rd(A_BUF, r);
      chk(r, {24'h0, lfsr_st[15:8]});
      $display("test shift done");
      end_sim;
   end
endmodule

// *** hdl/baud_divider.sv ***
// Independent divisor baud generator, one tick per divisor+1 clocks
`timescale 1ns/1ps
module baud_divider #(
   parameter int WIDTH = 16
) (
   input logic aclk,
   input logic aresetn,
   input logic [WIDTH-1:0] divisor,
   output logic tick
);
   logic [WIDTH-1:0] cnt_ff;
   logic tick_ff;
   wire wrap = (cnt_ff >= divisor);
   wire [WIDTH-1:0] nxt_cnt = wrap ? '0 : cnt_ff + 1'b1;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_ff <= '0;
         tick_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         tick_ff <= wrap;
      end
   end

   assign tick = tick_ff;
endmodule

// *** hdl/enhanced_uart.sv ***
// Enhanced UART with rate selection, break detect and AXI4-Lite registers
`timescale 1ns/1ps
module enhanced_uart
   import uart_pkg::*;
(
   input logic aclk,
   input logic aresetn,
   input logic por_n,
   input logic [7:0] awaddr,
   input logic awvalid,
   output logic awready,
   input logic [31:0] wdata,
   input logic [3:0] wstrb,
   input logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input logic bready,
   input logic [7:0] araddr,
   input logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input logic rready,
   input logic t1_overflow,
   input logic rxd_i,
   output logic rxd_o,
   output logic rxd_oe,
   output logic txd,
   output logic break_reset
);
   function automatic logic mapped(input logic [7:0] a);
      mapped = a inside {A_CTL, A_BUF, A_STAT, A_PWR, A_DIVL, A_DIVH, A_ADDR, A_SRC, A_RST};
   endfunction

   // Bus slave state
   logic aw_got_ff, w_got_ff, awready_ff, wready_ff, bvalid_ff;
   logic arready_ff, rvalid_ff, w_strb_ff;
   logic [7:0] aw_addr_ff;
   logic [31:0] w_data_ff, rdata_ff;
   logic [1:0] bresp_ff, rresp_ff;
   // Register state
   logic [7:0] ctl_ff, addr_ff, rxbuf_ff;
   logic [15:0] div_ff;
   logic dbl_ff, fe_ff, brk_ff, baud_doubling_select_ff, frame_error_view_select_ff, brg_sel_ff, brken_ff, brkf_ff;
   // Engine state
   tx_state_t tx_state_ff, nxt_tx_state;
   rx_state_t rx_state_ff, nxt_rx_state;
   logic [10:0] tx_sh_ff;
   logic [3:0] tx_bit_ff, tx_os_ff, rx_bit_ff, rx_os_ff;
   logic [7:0] hold_ff, rx_sh_ff, brk_cnt_ff;
   logic hold9_ff, hold_v_ff, rx9_ff, half_ff, t1_half_ff;
   logic txd_ff, rxd_o_ff, rxd_oe_ff, brk_rst_ff;
   logic brg_tick;

   // Write channel: address and data in either order
   wire aw_hs = awvalid & awready_ff;
   wire w_hs = wvalid & wready_ff;
   wire have_aw = aw_got_ff | aw_hs;
   wire have_w = w_got_ff | w_hs;
   wire do_wr = have_aw & have_w;
   wire [7:0] wa = aw_hs ? awaddr : aw_addr_ff;
   wire [31:0] wdat = w_hs ? wdata : w_data_ff;
   wire we = do_wr & (w_hs ? wstrb[0] : w_strb_ff);
   wire [7:0] wd = wdat[7:0];
   wire nxt_aw_got = have_aw & ~do_wr;
   wire nxt_w_got = have_w & ~do_wr;
   wire nxt_bvalid = do_wr | (bvalid_ff & ~bready);
   wire ar_hs = arvalid & arready_ff;
   wire nxt_rvalid = ar_hs | (rvalid_ff & ~rready);

   wire wr_ctl = we & (wa == A_CTL);
   wire wr_buf = we & (wa == A_BUF);
   wire wr_stat = we & (wa == A_STAT);
   wire wr_pwr = we & (wa == A_PWR);
   wire wr_divl = we & (wa == A_DIVL);
   wire wr_divh = we & (wa == A_DIVH);
   wire wr_addr = we & (wa == A_ADDR);
   wire wr_src = we & (wa == A_SRC);
   wire wr_rst = we & (wa == A_RST);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
      end else begin
         aw_got_ff <= nxt_aw_got;
         w_got_ff <= nxt_w_got;
         awready_ff <= ~nxt_aw_got & ~nxt_bvalid;
         wready_ff <= ~nxt_w_got & ~nxt_bvalid;
         bvalid_ff <= nxt_bvalid;
         if (do_wr) bresp_ff <= mapped(wa) ? RESP_OKAY : RESP_SLVERR;
      end
   end

   always_ff @(posedge aclk) begin
      if (aw_hs) aw_addr_ff <= awaddr;
      if (w_hs) begin
         w_data_ff <= wdata;
         w_strb_ff <= wstrb[0];
      end
   end

   // Mode, rate source and oversample tick
   wire sm0 = ctl_ff[CTL_SM0];
   wire mpe = ctl_ff[CTL_MPE];
   wire ri = ctl_ff[CTL_RI];
   uart_mode_t mode;
   assign mode = uart_mode_t'(ctl_ff[7:6]);
   wire shift = (mode == MODE_SHIFT);
   wire nine = ctl_ff[7];
   wire dbl_eff = dbl_ff & ~shift;
   wire var_tick = brg_sel_ff ? brg_tick : (t1_overflow & (baud_doubling_select_ff | t1_half_ff));
   wire os_tick = shift ? 1'b1 : (mode == MODE_9FIX) ? (baud_doubling_select_ff | half_ff) : var_tick;

   baud_divider #(.WIDTH(16)) u_brg (
      .aclk(aclk),
      .aresetn(aresetn),
      .divisor(div_ff),
      .tick(brg_tick)
   );

   // Transmitter
   wire tx_busy = (tx_state_ff == TX_SEND);
   wire rx_busy = (rx_state_ff == RX_RUN);
   wire [3:0] last_bit = nine ? LAST_9BIT : shift ? LAST_SHIFT : LAST_8BIT;
   wire tx_end = tx_busy & os_tick & (tx_os_ff == OS_LAST);
   wire tx_last = tx_end & (tx_bit_ff == last_bit);
   wire start_tx = hold_v_ff & (~tx_busy | tx_last) & ~(shift & rx_busy);
   wire live9 = ~dbl_eff & nine & (tx_bit_ff == NINTH_POS);
   wire tx_bit = live9 ? ctl_ff[CTL_TB8] : tx_sh_ff[0];
   wire [10:0] frame = shift ? {3'b111, hold_ff}
                     : nine ? {1'b1, hold9_ff, hold_ff, 1'b0}
                     : {2'b11, hold_ff, 1'b0};
   wire ti_set = dbl_eff ? start_tx : tx_last;

   always_comb begin
      nxt_tx_state = tx_state_ff;
      unique case (tx_state_ff)
         TX_IDLE: if (start_tx) nxt_tx_state = TX_SEND;
         TX_SEND: if (tx_last && !start_tx) nxt_tx_state = TX_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_state_ff <= TX_IDLE;
         hold_v_ff <= 1'b0;
      end else begin
         tx_state_ff <= nxt_tx_state;
         hold_v_ff <= wr_buf | (hold_v_ff & ~start_tx);
      end
   end

   always_ff @(posedge aclk) begin
      if (wr_buf) begin
         hold_ff <= wd;
         hold9_ff <= ctl_ff[CTL_TB8];
      end
      if (start_tx) begin
         tx_sh_ff <= frame;
         tx_bit_ff <= 4'h0;
         tx_os_ff <= 4'h0;
      end else if (tx_busy && os_tick) begin
         tx_os_ff <= tx_os_ff + 4'h1;
         if (tx_os_ff == OS_LAST) begin
            tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
            tx_bit_ff <= tx_bit_ff + 4'h1;
         end
      end
   end

   // Pins: shift mode puts data on rxd and the clock on txd
   wire shclk = tx_busy ? tx_os_ff[3] : rx_busy ? rx_os_ff[3] : 1'b1;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         txd_ff <= 1'b1;
         rxd_o_ff <= 1'b1;
         rxd_oe_ff <= 1'b0;
      end else begin
         txd_ff <= shift ? shclk : (tx_busy ? tx_bit : 1'b1);
         rxd_o_ff <= tx_busy ? tx_bit : 1'b1;
         rxd_oe_ff <= shift & tx_busy;
      end
   end

   // Receiver
   wire [3:0] samp_pt = shift ? OS_LAST : OS_MID;
   wire samp = rx_busy & os_tick & (rx_os_ff == samp_pt);
   wire is_data = shift | ((rx_bit_ff != 4'h0) & (rx_bit_ff <= 4'h8));
   wire rx_abort = samp & ~shift & (rx_bit_ff == 4'h0) & rxd_i;
   wire rx_done = samp & (rx_bit_ff == last_bit);
   wire [7:0] rx_data = shift ? {rxd_i, rx_sh_ff[7:1]} : rx_sh_ff;
   wire addr_ok = ~mpe | (rx9_ff & (rx_data == addr_ff));
   wire acc = shift | (nine ? addr_ok : (~mpe | rxd_i));
   wire ri_free = ~ri | (wr_ctl & ~wd[CTL_RI]);
   wire rx_take = rx_done & acc & ri_free;
   wire fe_set = rx_done & ~shift & ~rxd_i;
   wire rx_go_shift = shift & ctl_ff[CTL_REN] & ~ri & ~tx_busy & ~start_tx;
   wire rx_go_frame = ~shift & ctl_ff[CTL_REN] & os_tick & ~rxd_i;

   always_comb begin
      nxt_rx_state = rx_state_ff;
      unique case (rx_state_ff)
         RX_IDLE: if (rx_go_shift || rx_go_frame) nxt_rx_state = RX_RUN;
         RX_RUN: if (rx_done || rx_abort) nxt_rx_state = RX_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) rx_state_ff <= RX_IDLE;
      else rx_state_ff <= nxt_rx_state;
   end

   always_ff @(posedge aclk) begin
      if (!rx_busy) begin
         rx_bit_ff <= 4'h0;
         rx_os_ff <= shift ? 4'h0 : 4'h1;
      end else if (os_tick) begin
         rx_os_ff <= rx_os_ff + 4'h1;
         if (rx_os_ff == OS_LAST) rx_bit_ff <= rx_bit_ff + 4'h1;
      end
      if (samp && is_data) rx_sh_ff <= {rxd_i, rx_sh_ff[7:1]};
      if (samp && rx_bit_ff == NINTH_POS) rx9_ff <= rxd_i;
   end

   // Break: eleven bit periods of continuous low
   wire brk_hit = ~shift & ~rxd_i & os_tick & (brk_cnt_ff == BRK_TICKS - 8'h01);
   always_ff @(posedge aclk) begin
      if (!aresetn || rxd_i || shift) brk_cnt_ff <= 8'h00;
      else if (os_tick && brk_cnt_ff != BRK_TICKS) brk_cnt_ff <= brk_cnt_ff + 8'h01;
   end

   // Control register and flags; hardware set wins over software clear
   wire nxt_ri = rx_take | (wr_ctl ? wd[CTL_RI] : ri);
   wire nxt_ti = ti_set | (wr_ctl ? wd[CTL_TI] : ctl_ff[CTL_TI]);
   wire rb8_hw = nine ? rx9_ff : rxd_i;
   wire nxt_rb8 = (rx_take & ~shift) ? rb8_hw : wr_ctl ? wd[CTL_RB8] : ctl_ff[CTL_RB8];
   wire nxt_sm0 = (wr_ctl & ~frame_error_view_select_ff) ? wd[CTL_SM0] : sm0;
   wire [7:0] nxt_ctl = {nxt_sm0, wr_ctl ? wd[6:3] : ctl_ff[6:3], nxt_rb8, nxt_ti, nxt_ri};
   wire fe_wr = wr_stat | (wr_ctl & frame_error_view_select_ff);
   wire fe_wv = wr_stat ? wd[STAT_FE] : wd[CTL_SM0];
   wire nxt_fe = fe_set | (fe_wr ? fe_wv : fe_ff);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl_ff <= CTL_RST;
         fe_ff <= 1'b0;
         brk_ff <= 1'b0;
         dbl_ff <= 1'b0;
         baud_doubling_select_ff <= 1'b0;
         frame_error_view_select_ff <= 1'b0;
         div_ff <= DIV_RST;
         addr_ff <= ADDR_RST;
         brg_sel_ff <= 1'b0;
         brken_ff <= 1'b0;
         brk_rst_ff <= 1'b0;
         half_ff <= 1'b0;
         t1_half_ff <= 1'b0;
      end else begin
         ctl_ff <= nxt_ctl;
         fe_ff <= nxt_fe;
         brk_ff <= brk_hit | (wr_stat ? wd[STAT_BRK] : brk_ff);
         brk_rst_ff <= brk_hit & brken_ff;
         half_ff <= ~half_ff;
         if (t1_overflow) t1_half_ff <= ~t1_half_ff;
         if (wr_stat) dbl_ff <= wd[STAT_DBL];
         if (wr_pwr) baud_doubling_select_ff <= wd[PWR_BAUD_DOUBLING_SELECT];
         if (wr_pwr) frame_error_view_select_ff <= wd[PWR_FRAME_ERROR_VIEW_SELECT];
         if (wr_divl) div_ff[7:0] <= wd;
         if (wr_divh) div_ff[15:8] <= wd;
         if (wr_addr) addr_ff <= wd;
         if (wr_src) brg_sel_ff <= wd[SRC_BRG];
         if (wr_rst) brken_ff <= wd[RST_BRKEN];
      end
   end

   // Reset cause flag survives the block reset, cleared at power-on or by a write to its bit
   always_ff @(posedge aclk) begin
      if (!por_n) brkf_ff <= 1'b0;
      else brkf_ff <= (brk_hit & brken_ff) | (wr_rst ? wd[RST_BRKF] : brkf_ff);
      if (rx_take) rxbuf_ff <= rx_data;
   end

   // Read path
   wire [7:0] ctl_rd = {frame_error_view_select_ff ? fe_ff : sm0, ctl_ff[6:0]};
   wire [7:0] rd_val = (araddr == A_CTL) ? ctl_rd
                     : (araddr == A_BUF) ? rxbuf_ff
                     : (araddr == A_STAT) ? {dbl_ff, 3'b000, fe_ff, brk_ff, 2'b00}
                     : (araddr == A_PWR) ? {baud_doubling_select_ff, frame_error_view_select_ff, 6'h00}
                     : (araddr == A_DIVL) ? div_ff[7:0]
                     : (araddr == A_DIVH) ? div_ff[15:8]
                     : (araddr == A_ADDR) ? addr_ff
                     : (araddr == A_SRC) ? {7'h00, brg_sel_ff}
                     : (araddr == A_RST) ? {6'h00, brken_ff, brkf_ff}
                     : 8'h00;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
         rresp_ff <= RESP_OKAY;
      end else begin
         arready_ff <= ~nxt_rvalid;
         rvalid_ff <= nxt_rvalid;
         if (ar_hs) begin
            rdata_ff <= {24'h000000, rd_val};
            rresp_ff <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   assign awready = awready_ff;
   assign wready = wready_ff;
   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;
   assign arready = arready_ff;
   assign rvalid = rvalid_ff;
   assign rdata = rdata_ff;
   assign rresp = rresp_ff;
   assign txd = txd_ff;
   assign rxd_o = rxd_o_ff;
   assign rxd_oe = rxd_oe_ff;
   assign break_reset = brk_rst_ff;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_shift_rate;
      (shift && tx_busy && !start_tx) |=> (tx_os_ff == $past(tx_os_ff) + 4'h1);
   endproperty
   a_shift_rate: assert property (p_shift_rate) else $error("shift rate not clk/16");

   property p_fix_half;
      (mode == MODE_9FIX && !baud_doubling_select_ff && os_tick && !wr_ctl && !wr_pwr) |=> !os_tick;
   endproperty
   a_fix_half: assert property (p_fix_half) else $error("fixed mode /32 broken");

   property p_t1_half;
      (!shift && mode != MODE_9FIX && !brg_sel_ff && !baud_doubling_select_ff && os_tick)
         |-> (t1_overflow && t1_half_ff);
   endproperty
   a_t1_half: assert property (p_t1_half) else $error("timer 1 rate not halved");

   property p_start_bit;
      (start_tx && !shift && !wr_ctl) |=> ##1 !txd;
   endproperty
   a_start_bit: assert property (p_start_bit) else $error("no start bit");

   property p_back2back;
      (tx_last && hold_v_ff && !shift) |=> (tx_busy && tx_bit_ff == 4'h0);
   endproperty
   a_back2back: assert property (p_back2back) else $error("extra gap");

   property p_dbl_ti;
      (start_tx && dbl_eff) |=> ctl_ff[CTL_TI];
   endproperty
   a_dbl_ti: assert property (p_dbl_ti) else $error("no early tx flag");

   property p_break;
      brk_hit |=> (brk_ff && (break_reset == $past(brken_ff)));
   endproperty
   a_break: assert property (p_break) else $error("break not flagged");

   property p_fe;
      fe_set |=> fe_ff;
   endproperty
   a_fe: assert property (p_fe) else $error("framing error lost");

   property p_rb8_stop;
      (rx_take && mode == MODE_8BIT) |=> (ctl_ff[CTL_RB8] == $past(rxd_i));
   endproperty
   a_rb8_stop: assert property (p_rb8_stop) else $error("stop not in rb8");
endmodule

// *** hdl/uart_pkg.sv ***
// Register map, field positions, reset values and counts for the enhanced UART
// Notes on behaviour
// - Shift mode: data on serial in/out pin, clock on txd, 8 bits LSB first.
// - Shift mode bit rate is always cpu clock divided by sixteen.
// - 8-bit framed mode sends start 0, eight data bits LSB first, stop 1.
// - 8-bit framed mode stores received stop bit into received ninth bit.
// - 8-bit framed mode rate comes from timer 1 overflow or divisor generator.
// - 9-bit modes send start, eight data bits, transmit ninth bit, stop.
// - 9-bit modes store received ninth bit; stop bit is dropped.
// - Fixed 9-bit mode runs at cpu clock over 16 or 32, doubling bit picks.
// - Variable 9-bit mode equals fixed mode but uses variable rate source.
// - Divisor generator counts cpu clocks against 16-bit high:low divisor.
// - Timer 1 overflow rate is halved while baud doubling select is clear.
// - Framing error in status; control bit 7 shows it when view select set.
// - Eleven low bit periods flag break; break may request device reset.
// - Double buffered next character follows after a single stop bit.
// - Double buffer enable clear sends ninth bit live and sets TI at frame end; set sets TI early.
// - Double buffered transmit interrupt fires when holding stage frees.
// - Double buffered: ninth bit written first, captured with the data byte.
// - Rate sources: fixed divide, timer 1 overflow, divisor generator only.
// - Break caused reset sets its own flag in the reset cause register.
package uart_pkg;
   localparam logic [7:0] A_CTL = 8'h00;
   localparam logic [7:0] A_BUF = 8'h04;
   localparam logic [7:0] A_STAT = 8'h08;
   localparam logic [7:0] A_PWR = 8'h0C;
   localparam logic [7:0] A_DIVL = 8'h10;
   localparam logic [7:0] A_DIVH = 8'h14;
   localparam logic [7:0] A_ADDR = 8'h18;
   localparam logic [7:0] A_SRC = 8'h1C;
   localparam logic [7:0] A_RST = 8'h20;
   localparam int CTL_SM0 = 7;
   localparam int CTL_MPE = 5;
   localparam int CTL_REN = 4;
   localparam int CTL_TB8 = 3;
   localparam int CTL_RB8 = 2;
   localparam int CTL_TI = 1;
   localparam int CTL_RI = 0;
   localparam int STAT_DBL = 7;
   localparam int STAT_FE = 3;
   localparam int STAT_BRK = 2;
   localparam int PWR_BAUD_DOUBLING_SELECT = 7;
   localparam int PWR_FRAME_ERROR_VIEW_SELECT = 6;
   localparam int SRC_BRG = 0;
   localparam int RST_BRKF = 0;
   localparam int RST_BRKEN = 1;
   localparam logic [7:0] CTL_RST = 8'h00;
   localparam logic [15:0] DIV_RST = 16'h0000;
   localparam logic [7:0] ADDR_RST = 8'h00;
   localparam logic [3:0] OS_LAST = 4'hF;
   localparam logic [3:0] OS_MID = 4'h7;
   localparam logic [3:0] LAST_SHIFT = 4'h7;
   localparam logic [3:0] LAST_8BIT = 4'h9;
   localparam logic [3:0] LAST_9BIT = 4'hA;
   localparam logic [3:0] NINTH_POS = 4'h9;
   localparam logic [7:0] BRK_TICKS = 8'hB0;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {
      MODE_SHIFT = 2'b00,
      MODE_8BIT = 2'b01,
      MODE_9FIX = 2'b10,
      MODE_9VAR = 2'b11
   } uart_mode_t;
   typedef enum logic {TX_IDLE = 1'b0, TX_SEND = 1'b1} tx_state_t;
   typedef enum logic {RX_IDLE = 1'b0, RX_RUN = 1'b1} rx_state_t;
endpackage
